/* verilog/eifm_top.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module eifm_top
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,

  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [eifm_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [eifm_pkg::DATA_W-1:0] pwdata_i,
  output logic [eifm_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,

  // Capture unit events, one-cycle pulses, bit 0 is unit 1
  input wire logic [eifm_pkg::GRP_C_W-1:0] capture_unit_event_i,

  // Flags of the timer groups, held by their own flag registers
  input wire logic [eifm_pkg::GRP_A_W-1:0] timer_compare_flag_i,
  input wire logic [eifm_pkg::GRP_B_W-1:0] timer23_flag_i,

  // Mask values toward the timer flag logic
  output logic [eifm_pkg::GRP_A_W-1:0] timer_compare_irq_enable_o,
  output logic [eifm_pkg::GRP_B_W-1:0] timer23_irq_enable_o,

  // Interrupt requests toward the core
  output eifm_pkg::eifm_irq_s irq_o
);

  // ----------------------------------------------------------------------
  // Priority encoder for the vector registers
  // ----------------------------------------------------------------------
  // The lowest set bit wins and its id is its position plus one.
  // Ids fit in six bits because no group has more than sixteen flags.
  function automatic logic [eifm_pkg::VEC_W-1:0] eifm_vector(input logic [15:0] active);
    logic [eifm_pkg::VEC_W-1:0] id;
    id = eifm_pkg::VEC_NONE;
    for (int i = 15; i >= 0; i--)
    begin
      if (active[i])
      begin
        id = eifm_pkg::VEC_W'(i + 1);
      end
    end
    return id;
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  // Registers end in _r and their next values in _nxt; the rest is combinational.
  logic [eifm_pkg::GRP_A_W-1:0] mask_a_r;
  logic [eifm_pkg::GRP_A_W-1:0] mask_a_nxt;
  logic [eifm_pkg::GRP_B_W-1:0] mask_b_r;
  logic [eifm_pkg::GRP_B_W-1:0] mask_b_nxt;
  logic [eifm_pkg::GRP_C_W-1:0] mask_c_r;
  logic [eifm_pkg::GRP_C_W-1:0] mask_c_nxt;
  logic [eifm_pkg::GRP_C_W-1:0] pend_c_r;
  logic [eifm_pkg::GRP_C_W-1:0] pend_c_nxt;
  logic [eifm_pkg::GRP_C_W-1:0] clear_c;
  logic [eifm_pkg::DATA_W-1:0] prdata_r;
  logic [eifm_pkg::DATA_W-1:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  eifm_pkg::eifm_irq_s irq_r;
  eifm_pkg::eifm_irq_s irq_nxt;
  logic [eifm_pkg::IDX_W-1:0] idx;
  logic setup_phase;
  logic wr_commit;
  logic [eifm_pkg::GRP_A_W-1:0] active_a;
  logic [eifm_pkg::GRP_B_W-1:0] active_b;
  logic [eifm_pkg::GRP_C_W-1:0] active_c;
  logic sel_mask_a;
  logic sel_mask_b;
  logic sel_mask_c;
  logic sel_pend_c;
  logic wr_pend_c;
  logic req_a;
  logic req_b;
  logic req_c;
  logic req_any;
  logic [eifm_pkg::DATA_W-1:0] rd_mask_a;
  logic [eifm_pkg::DATA_W-1:0] rd_mask_b;
  logic [eifm_pkg::DATA_W-1:0] rd_mask_c;
  logic [eifm_pkg::DATA_W-1:0] rd_pend_c;
  logic [eifm_pkg::DATA_W-1:0] rd_vec_a;
  logic [eifm_pkg::DATA_W-1:0] rd_vec_b;
  logic [eifm_pkg::DATA_W-1:0] rd_vec_c;

  // A write takes effect only in the access cycle in which ready is high,
  // so a setup cycle on its own never changes a register.
  assign idx = paddr_i[eifm_pkg::ADDR_W-1:2];
  assign setup_phase = psel_i & ~penable_i;
  assign wr_commit = psel_i & penable_i & pready_r & pwrite_i;

  // Active bits are flags that are both set and enabled; they feed the
  // vectors and the requests alike.
  assign active_a = timer_compare_flag_i & mask_a_r;
  assign active_b = timer23_flag_i & mask_b_r;
  assign active_c = pend_c_r & mask_c_r;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  // The two low address bits are ignored, so each register answers on one
  // whole aligned word and byte lanes play no part.
  assign sel_mask_a = (idx == eifm_pkg::IDX_TIMER_COMPARE_IRQ_ENABLE);
  assign sel_mask_b = (idx == eifm_pkg::IDX_TIMER23_IRQ_ENABLE);
  assign sel_mask_c = (idx == eifm_pkg::IDX_CAPTURE_IRQ_ENABLE);
  assign sel_pend_c = (idx == eifm_pkg::IDX_CAPTURE_IRQ_PENDING);
  assign wr_pend_c = wr_commit & sel_pend_c;

  // ----------------------------------------------------------------------
  // Read values
  // ----------------------------------------------------------------------
  // Each word is zero-extended, so reserved upper bits always read as zero.
  // The vectors follow the live flags and masks; reading one never clears
  // a flag, software clears it through the pending or timer flag register.
  assign rd_mask_a = 32'(mask_a_r);
  assign rd_mask_b = 32'(mask_b_r);
  assign rd_mask_c = 32'(mask_c_r);
  assign rd_pend_c = 32'(pend_c_r);
  assign rd_vec_a = 32'(eifm_vector(16'(active_a)));
  assign rd_vec_b = 32'(eifm_vector(16'(active_b)));
  assign rd_vec_c = 32'(eifm_vector(16'(active_c)));

  // ----------------------------------------------------------------------
  // APB answer: read data and status are prepared in the setup cycle
  // ----------------------------------------------------------------------
  // Preparing the answer one cycle early keeps every bus output on a
  // flip-flop while still giving a zero-wait access phase.
  always_comb
  begin
    prdata_nxt = eifm_pkg::RST_RDATA;
    pslverr_nxt = 1'b0;
    pready_nxt = 1'b0;
    // Outside a setup cycle the answer returns to idle, so ready, error and
    // data stand for exactly one access cycle.
    if (setup_phase)
    begin
      pready_nxt = 1'b1;
      unique case (idx)
        eifm_pkg::IDX_TIMER_COMPARE_IRQ_ENABLE:
        begin
          prdata_nxt = rd_mask_a;
        end
        eifm_pkg::IDX_TIMER23_IRQ_ENABLE:
        begin
          prdata_nxt = rd_mask_b;
        end
        eifm_pkg::IDX_CAPTURE_IRQ_ENABLE:
        begin
          prdata_nxt = rd_mask_c;
        end
        eifm_pkg::IDX_CAPTURE_IRQ_PENDING:
        begin
          prdata_nxt = rd_pend_c;
        end
        eifm_pkg::IDX_VECTOR_A:
        begin
          prdata_nxt = rd_vec_a;
        end
        eifm_pkg::IDX_VECTOR_B:
        begin
          prdata_nxt = rd_vec_b;
        end
        eifm_pkg::IDX_VECTOR_C:
        begin
          prdata_nxt = rd_vec_c;
        end
        default:
        begin
          // An unmapped index answers with an error and zero data; a write
          // there changes nothing.
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // Reset leaves the bus idle: no ready, no error and zero data.
      prdata_r <= eifm_pkg::RST_RDATA;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------------
  // Three independent masks, each aligned with its flag group.
  // Data bits above each mask are dropped, which is what keeps the
  // reserved fields reading zero.
  always_comb
  begin
    mask_a_nxt = mask_a_r;
    mask_b_nxt = mask_b_r;
    mask_c_nxt = mask_c_r;
    // Writes to the vector words fall through all three tests and change
    // nothing, so the vectors stay read-only without an error.
    if (wr_commit)
    begin
      if (sel_mask_a)
      begin
        mask_a_nxt = pwdata_i[eifm_pkg::GRP_A_W-1:0];
      end
      if (sel_mask_b)
      begin
        mask_b_nxt = pwdata_i[eifm_pkg::GRP_B_W-1:0];
      end
      if (sel_mask_c)
      begin
        mask_c_nxt = pwdata_i[eifm_pkg::GRP_C_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // Every enable starts cleared, so no source can interrupt before
      // software has set it up.
      mask_a_r <= eifm_pkg::RST_MASK_A;
      mask_b_r <= eifm_pkg::RST_MASK_B;
      mask_c_r <= eifm_pkg::RST_MASK_C;
    end
    else
    begin
      mask_a_r <= mask_a_nxt;
      mask_b_r <= mask_b_nxt;
      mask_c_r <= mask_c_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Capture pending flags
  // ----------------------------------------------------------------------
  // Only the low bits of the write data can clear; upper data bits are
  // dropped, so writes to the reserved field have no effect.
  assign clear_c = wr_pend_c ? pwdata_i[eifm_pkg::GRP_C_W-1:0] : eifm_pkg::RST_PEND_C;

  // An event in the same cycle as its clear keeps the flag set.
  // One flag per capture unit; bit 0 belongs to unit 1.
  genvar g;
  generate
    for (g = 0; g < eifm_pkg::GRP_C_W; g++)
    begin : g_capture_flag
      always_comb
      begin
        pend_c_nxt[g] = (pend_c_r[g] & ~clear_c[g]) | capture_unit_event_i[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // Flags come up cleared; an event during reset itself is lost.
      pend_c_r <= eifm_pkg::RST_PEND_C;
    end
    else
    begin
      pend_c_r <= pend_c_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------------
  // A group asks for service while any of its flags is set and enabled; the
  // timer groups take their flags from outside, the capture group from here.
  assign req_a = |active_a;
  assign req_b = |active_b;
  assign req_c = |active_c;
  assign req_any = req_a | req_b | req_c;

  always_comb
  begin
    irq_nxt.grp_a = req_a;
    irq_nxt.grp_b = req_b;
    irq_nxt.grp_c = req_c;
    irq_nxt.any = req_any;
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      // Registering the requests costs one cycle of latency but keeps the
      // core from seeing decode glitches.
      irq_r <= eifm_pkg::RST_IRQ;
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  // The timer flag logic outside sees the stored masks, never a write that
  // is still in flight.
  assign timer_compare_irq_enable_o = mask_a_r;
  assign timer23_irq_enable_o = mask_b_r;
  assign irq_o = irq_r;

endmodule

`default_nettype wire

/* shared/eifm_pkg.sv */
package eifm_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 16;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_TIMER_COMPARE_IRQ_ENABLE = 16'h742C;
  localparam logic [IDX_W-1:0] IDX_TIMER23_IRQ_ENABLE = 16'h742D;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_IRQ_ENABLE = 16'h742E;
  localparam logic [IDX_W-1:0] IDX_CAPTURE_IRQ_PENDING = 16'h7431;
  localparam logic [IDX_W-1:0] IDX_VECTOR_A = 16'h7432;
  localparam logic [IDX_W-1:0] IDX_VECTOR_B = 16'h7433;
  localparam logic [IDX_W-1:0] IDX_VECTOR_C = 16'h7434;

  // ----------------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned GRP_A_W = 11;
  localparam int unsigned GRP_B_W = 8;
  localparam int unsigned GRP_C_W = 4;
  localparam int unsigned VEC_W = 6;
  localparam logic [GRP_A_W-1:0] RST_MASK_A = 11'h000;
  localparam logic [GRP_B_W-1:0] RST_MASK_B = 8'h00;
  localparam logic [GRP_C_W-1:0] RST_MASK_C = 4'h0;
  localparam logic [GRP_C_W-1:0] RST_PEND_C = 4'h0;
  localparam logic [VEC_W-1:0] VEC_NONE = 6'h00;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Interrupt request outputs
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic any;
    logic grp_c;
    logic grp_b;
    logic grp_a;
  } eifm_irq_s;

  localparam eifm_irq_s RST_IRQ = '{any: 1'b0, grp_c: 1'b0, grp_b: 1'b0, grp_a: 1'b0};

endpackage

/* dv/eifm_core_mdl.sv */
`timescale 1ns/1ns
`default_nettype none
// Core side: records every interrupt request level that it has taken.
module eifm_core_mdl
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire eifm_pkg::eifm_irq_s irq_i,
  output logic [3:0] seen_o
);
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      seen_o <= 4'h0;
    else
      seen_o <= seen_o | irq_i;
endmodule
`default_nettype wire

/* dv/eifm_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module eifm_chk
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [eifm_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [eifm_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [eifm_pkg::DATA_W-1:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [eifm_pkg::GRP_A_W-1:0] timer_compare_flag_i,
  input wire logic [eifm_pkg::GRP_B_W-1:0] timer23_flag_i,
  input wire logic [eifm_pkg::GRP_A_W-1:0] timer_compare_irq_enable_o,
  input wire logic [eifm_pkg::GRP_B_W-1:0] timer23_irq_enable_o,
  input wire eifm_pkg::eifm_irq_s irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence acc_s(w, idx);
    psel_i && penable_i && pready_o && pwrite_i == w && paddr_i[17:2] == idx;
  endsequence
  rdy_setup_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no ready");
  rdy_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
  err_rdy_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  mask_a_wr_a: assert property (acc_s(1'b1, eifm_pkg::IDX_TIMER_COMPARE_IRQ_ENABLE) |=>
    timer_compare_irq_enable_o == $past(pwdata_i[10:0])) else $error("mask a write lost");
  mask_b_wr_a: assert property (acc_s(1'b1, eifm_pkg::IDX_TIMER23_IRQ_ENABLE) |=>
    timer23_irq_enable_o == $past(pwdata_i[7:0])) else $error("mask b write lost");
  pend_rsv_a: assert property (acc_s(1'b0, eifm_pkg::IDX_CAPTURE_IRQ_PENDING) |->
    prdata_o[31:4] == 28'h0) else $error("pending upper bits set");
  grp_a_irq_a: assert property (1'b1 |=> irq_o.grp_a ==
    $past(|(timer_compare_flag_i & timer_compare_irq_enable_o))) else $error("irq a wrong");
  grp_b_irq_a: assert property (1'b1 |=> irq_o.grp_b ==
    $past(|(timer23_flag_i & timer23_irq_enable_o))) else $error("irq b wrong");
  any_irq_a: assert property (irq_o.any == (irq_o.grp_a | irq_o.grp_b | irq_o.grp_c))
    else $error("any irq wrong");
endmodule
bind eifm_top eifm_chk u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .timer_compare_flag_i(timer_compare_flag_i), .timer23_flag_i(timer23_flag_i),
  .timer_compare_irq_enable_o(timer_compare_irq_enable_o),
  .timer23_irq_enable_o(timer23_irq_enable_o), .irq_o(irq_o));
`default_nettype wire

/* dv/event_interrupt_flag_mask_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module event_interrupt_flag_mask_bench;
  logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err_q;
  logic [17:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_q;
  logic [3:0] cap_i, seen;
  logic [10:0] ta, en_a;
  logic [7:0] tb, en_b;
  eifm_pkg::eifm_irq_s irq;
  int fail_count, samples_checked;
  logic [15:0] u_masks [5] = '{16'h742C, 16'h742D, 16'h742E, 16'h7431, 16'h7434};
  eifm_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .capture_unit_event_i(cap_i),
    .timer_compare_flag_i(ta), .timer23_flag_i(tb), .timer_compare_irq_enable_o(en_a),
    .timer23_irq_enable_o(en_b), .irq_o(irq));
  eifm_core_mdl u_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .irq_i(irq), .seen_o(seen));
  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, idx, 2'b00, wd};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1 && ++n < 20);
    if (pready_o !== 1'b1)
    begin
      fail_count++;
      $display("unexpected at %0t: no ready", $time);
    end
    rd_q = prdata_o;
    err_q = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input logic e);
    apb(1'b0, idx, 32'h0);
    chk(rd_q, exp);
    chk({31'h0, err_q}, {31'h0, e});
  endtask
  task automatic irqc(input logic [3:0] exp);
    repeat (2) @(posedge clk_i);
    chk({28'h0, irq}, {28'h0, exp});
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_masks();
    foreach (u_masks[i]) rdc(u_masks[i], 32'h0, 1'b0);
    apb(1'b1, eifm_pkg::IDX_TIMER_COMPARE_IRQ_ENABLE, 32'hFFFF_FFFF);
    apb(1'b1, eifm_pkg::IDX_TIMER23_IRQ_ENABLE, 32'hFFFF_FFFF);
    apb(1'b1, eifm_pkg::IDX_CAPTURE_IRQ_ENABLE, 32'hFFFF_FFFF);
    rdc(eifm_pkg::IDX_TIMER_COMPARE_IRQ_ENABLE, 32'h7FF, 1'b0);
    rdc(eifm_pkg::IDX_TIMER23_IRQ_ENABLE, 32'hFF, 1'b0);
    rdc(eifm_pkg::IDX_CAPTURE_IRQ_ENABLE, 32'hF, 1'b0);
    chk({13'h0, en_b, en_a}, 32'h7_FFFF);
  endtask
  task automatic t_capture();
    @(posedge clk_i);
    cap_i <= 4'hA;
    @(posedge clk_i);
    cap_i <= 4'h0;
    rdc(eifm_pkg::IDX_CAPTURE_IRQ_PENDING, 32'hA, 1'b0);
    rdc(eifm_pkg::IDX_VECTOR_C, 32'h2, 1'b0);
    irqc(4'hC);
    apb(1'b1, eifm_pkg::IDX_CAPTURE_IRQ_PENDING, 32'hFFFF_FFF2);
    rdc(eifm_pkg::IDX_CAPTURE_IRQ_PENDING, 32'h8, 1'b0);
    apb(1'b1, eifm_pkg::IDX_CAPTURE_IRQ_ENABLE, 32'h0);
    irqc(4'h0);
    apb(1'b1, eifm_pkg::IDX_CAPTURE_IRQ_PENDING, 32'h8);
    rdc(eifm_pkg::IDX_CAPTURE_IRQ_PENDING, 32'h0, 1'b0);
  endtask
  task automatic t_timers();
    ta <= 11'h400;
    tb <= 8'h80;
    irqc(4'hB);
    rdc(eifm_pkg::IDX_VECTOR_A, 32'hB, 1'b0);
    apb(1'b1, eifm_pkg::IDX_TIMER_COMPARE_IRQ_ENABLE, 32'h3FF);
    irqc(4'hA);
    rdc(16'h7435, 32'h0, 1'b1);
    chk({28'h0, seen}, 32'hF);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    close_out();
  end
  initial
  begin
    {rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {cap_i, ta, tb} = '0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_masks();
    t_capture();
    t_timers();
    close_out();
  end
endmodule
`default_nettype wire
